// *** design/pcie_dma_defines.svh ***
// offsets, field positions, codes and reset values of the dma control block
`ifndef PCIE_DMA_DEFINES_SVH
`define PCIE_DMA_DEFINES_SVH
`define OFF_SCRATCHPAD      20'h00000
`define OFF_DIRECTION       20'h08008
`define OFF_SIZE            20'h08010
`define OFF_CYCLE_COUNT     20'h08018
`define OFF_DONE_STATUS     20'h08020
`define OFF_HOST_BASE       20'h08028
`define OFF_BLINK_TRIGGER   20'h08030
`define OFF_DIP_SWITCH      20'h13080
`define OFF_LED_CONTROL     20'h13088
`define WIN_FIRST           1'h0
`define WIN_SECOND          1'h1
`define DIR_SRAM_TO_HOST    32'h11AA1111
`define DIR_HOST_TO_SRAM    32'h11AA2222
`define BLINK_CODE          32'h11AA0F0F
`define SIZE_8K             32'h00002000
`define SIZE_16K            32'h00004000
`define SIZE_32K            32'h00008000
`define DIP_LSB             8
`define STATUS_DONE_BIT     0
`define STATUS_BUSY_BIT     1
`define PKT_BEATS           3'h7
`define PKT_BEAT_BYTES      2
`define REG_RESET           32'h00000000
`endif

// *** design/pcie_dma_pkg.sv ***
// types shared by the dma control block
package pcie_dma_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PKT   = 2'b01,
        ST_DATA  = 2'b10,
        ST_FLUSH = 2'b11
    } dma_state_t;

    // one register access from the host side
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        win;
        logic [19:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage : pcie_dma_pkg

// *** design/pcie_dma_control_regs.sv ***
// dma control registers, transfer engine and its data fifo
`timescale 1ns/10ps
`include "pcie_dma_defines.svh"

// ****************************************
// data fifo
// ****************************************
module dma_data_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_arst_n,
    input  wire logic                       i_in_valid,
    output logic                            o_in_ready,
    input  wire logic [WIDTH-1:0]           i_in_data,
    output logic                            o_out_valid,
    input  wire logic                       i_out_ready,
    output logic [WIDTH-1:0]                o_out_data,
    output logic [$clog2(DEPTH):0]          o_count
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } fifo_state_t;
    fifo_state_t st, next_st;
    logic push, pop;

    // handshakes on both sides
    assign o_in_ready  = (st.count != AW'(0) + (AW+1)'(DEPTH));
    assign o_out_valid = (st.count != '0);
    assign o_out_data  = st.mem[st.rptr];
    assign o_count     = st.count;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = i_in_data;
            next_st.wptr         = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + AW'(1);
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + AW'(1);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : dma_data_fifo

// ****************************************
// control registers and transfer engine
// ****************************************
module pcie_dma_control_regs #(
    parameter int WCNT_W     = 16,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_arst_n,
    input  wire pcie_dma_pkg::reg_req_t i_reg_req,
    output logic [31:0]                 o_reg_rdata,
    output logic                        o_reg_rvalid,
    output logic                        o_pkt_req,
    output logic [31:0]                 o_pkt_addr,
    output logic                        o_pkt_to_host,
    input  wire logic                   i_pkt_ready,
    input  wire logic                   i_host_rx_valid,
    input  wire logic [31:0]            i_host_rx_data,
    output logic                        o_host_rx_ready,
    output logic                        o_host_tx_valid,
    output logic [31:0]                 o_host_tx_data,
    input  wire logic                   i_host_tx_ready,
    output logic                        o_sram_req,
    output logic                        o_sram_we,
    output logic [31:0]                 o_sram_addr,
    output logic [31:0]                 o_sram_wdata,
    input  wire logic                   i_sram_ready,
    input  wire logic [31:0]            i_sram_rdata,
    output logic                        o_blink_req,
    output logic [7:0]                  o_led,
    input  wire logic [3:0]             i_dip_switch
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        pcie_dma_pkg::dma_state_t fsm;
        logic [31:0]              scratch;
        logic [31:0]              dir;
        logic [31:0]              size;
        logic [31:0]              base;
        logic [31:0]              blink;
        logic [7:0]               led;
        logic [31:0]              cycles;
        logic                     done;
        logic                     busy;
        logic                     to_sram;
        logic [WCNT_W-1:0]        total;
        logic [WCNT_W-1:0]        host_cnt;
        logic [WCNT_W-1:0]        sram_cnt;
        logic [2:0]               beat;
        logic                     pkt_req;
        logic [31:0]              pkt_addr;
        logic                     rx_ready;
        logic                     rd_req;
        logic [31:0]              rdata;
        logic                     rvalid;
        logic                     blink_req;
    } ctl_state_t;
    ctl_state_t st, next_st;

    logic              fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [31:0]       fifo_in_data, fifo_out_data;
    logic [CW-1:0]     fifo_count;
    logic              h_fire, s_fire, start, room;
    logic [WCNT_W-1:0] host_nxt, sram_nxt;

    // register hit in a given window at a given offset
    function automatic logic hit(input pcie_dma_pkg::reg_req_t r, input logic w,
                                 input logic [19:0] off);
        hit = (r.win == w) && (r.addr == off);
    endfunction : hit

    // handshakes of the host side and the sram side
    assign start   = i_reg_req.wr && hit(i_reg_req, `WIN_SECOND, `OFF_DIRECTION) && !st.busy
                     && (i_reg_req.wdata == `DIR_SRAM_TO_HOST
                         || i_reg_req.wdata == `DIR_HOST_TO_SRAM);
    assign h_fire  = st.to_sram ? (i_host_rx_valid && st.rx_ready)
                                : (o_host_tx_valid && i_host_tx_ready);
    assign s_fire  = st.to_sram ? (fifo_out_valid && i_sram_ready && st.busy)
                                : (st.rd_req && i_sram_ready);
    assign room    = (fifo_count <= CW'(FIFO_DEPTH - 2));
    assign host_nxt = st.host_cnt + WCNT_W'(h_fire);
    assign sram_nxt = st.sram_cnt + WCNT_W'(s_fire);

    // fifo joins host side and sram side, direction picks the ends
    assign fifo_in_valid  = st.to_sram ? (i_host_rx_valid && st.rx_ready)
                                       : (st.rd_req && i_sram_ready);
    assign fifo_in_data   = st.to_sram ? i_host_rx_data : i_sram_rdata;
    assign fifo_out_ready = st.to_sram ? (i_sram_ready && st.busy)
                                       : (st.fsm == pcie_dma_pkg::ST_DATA && i_host_tx_ready);

    dma_data_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (fifo_in_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (fifo_in_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_out_ready),
        .o_out_data  (fifo_out_data),
        .o_count     (fifo_count)
    );

    // register file, packet sequencing and completion
    always_comb begin
        next_st           = st;
        next_st.rvalid    = i_reg_req.rd;
        next_st.blink_req = 1'b0;
        next_st.rdata     = `REG_RESET;
        if (i_reg_req.rd) begin
            if (hit(i_reg_req, `WIN_SECOND, `OFF_SCRATCHPAD))    next_st.rdata = st.scratch;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_DIRECTION))     next_st.rdata = st.dir;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_SIZE))          next_st.rdata = st.size;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_CYCLE_COUNT))   next_st.rdata = st.cycles;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_HOST_BASE))     next_st.rdata = st.base;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_BLINK_TRIGGER)) next_st.rdata = st.blink;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_DONE_STATUS)) begin
                next_st.rdata[`STATUS_DONE_BIT] = st.done;
                next_st.rdata[`STATUS_BUSY_BIT] = st.busy;
            end
            if (hit(i_reg_req, `WIN_FIRST, `OFF_DIP_SWITCH))
                next_st.rdata[`DIP_LSB +: 4] = i_dip_switch;
            if (hit(i_reg_req, `WIN_FIRST, `OFF_LED_CONTROL))
                next_st.rdata[7:0] = st.led;
        end
        if (i_reg_req.wr) begin
            if (hit(i_reg_req, `WIN_SECOND, `OFF_SCRATCHPAD))
                next_st.scratch = i_reg_req.wdata;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_DIRECTION) && !st.busy)
                next_st.dir = i_reg_req.wdata;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_SIZE) && !st.busy)
                next_st.size = i_reg_req.wdata;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_HOST_BASE) && !st.busy)
                next_st.base = i_reg_req.wdata;
            if (hit(i_reg_req, `WIN_SECOND, `OFF_BLINK_TRIGGER)) begin
                next_st.blink     = i_reg_req.wdata;
                next_st.blink_req = (i_reg_req.wdata == `BLINK_CODE);
            end
            if (hit(i_reg_req, `WIN_FIRST, `OFF_LED_CONTROL))
                next_st.led = i_reg_req.wdata[7:0];
        end
        // transfer engine
        next_st.host_cnt = host_nxt;
        next_st.sram_cnt = sram_nxt;
        if (st.busy) begin
            next_st.cycles = st.cycles + 32'h00000001;
        end
        unique case (st.fsm)
            pcie_dma_pkg::ST_IDLE: begin
                if (start) begin
                    next_st.busy     = 1'b1;
                    next_st.done     = 1'b0;
                    next_st.cycles   = `REG_RESET;
                    next_st.to_sram  = (i_reg_req.wdata == `DIR_HOST_TO_SRAM);
                    next_st.total    = st.size[`PKT_BEAT_BYTES +: WCNT_W];
                    next_st.host_cnt = '0;
                    next_st.sram_cnt = '0;
                    next_st.beat     = '0;
                    next_st.pkt_req  = 1'b1;
                    next_st.pkt_addr = st.base;
                    next_st.fsm      = pcie_dma_pkg::ST_PKT;
                end
            end
            pcie_dma_pkg::ST_PKT: begin
                if (i_pkt_ready) begin
                    next_st.pkt_req = 1'b0;
                    next_st.fsm     = pcie_dma_pkg::ST_DATA;
                end
            end
            pcie_dma_pkg::ST_DATA: begin
                if (h_fire) begin
                    next_st.beat = st.beat + 3'h1;
                    if (host_nxt == st.total) begin
                        next_st.fsm = pcie_dma_pkg::ST_FLUSH;
                    end else if (st.beat == `PKT_BEATS) begin
                        next_st.fsm      = pcie_dma_pkg::ST_PKT;
                        next_st.pkt_req  = 1'b1;
                        next_st.pkt_addr = st.base + {host_nxt, 2'b00};
                    end
                end
            end
            pcie_dma_pkg::ST_FLUSH: begin
            end
        endcase
        // last beat ends the transfer, count frozen from here
        if (st.busy && (st.to_sram ? sram_nxt == st.total : host_nxt == st.total)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.fsm  = pcie_dma_pkg::ST_IDLE;
        end
        next_st.rx_ready = next_st.busy && next_st.to_sram && room
                           && next_st.fsm == pcie_dma_pkg::ST_DATA
                           && !(h_fire && st.beat == `PKT_BEATS);
        next_st.rd_req   = next_st.busy && !next_st.to_sram && room
                           && (sram_nxt != next_st.total) && !(st.rd_req && !s_fire);
        if (st.rd_req && !s_fire) next_st.rd_req = 1'b1;
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign o_reg_rdata     = st.rdata;
    assign o_reg_rvalid    = st.rvalid;
    assign o_pkt_req       = st.pkt_req;
    assign o_pkt_addr      = st.pkt_addr;
    assign o_pkt_to_host   = !st.to_sram;
    assign o_host_rx_ready = st.rx_ready;
    assign o_host_tx_valid = !st.to_sram && st.fsm == pcie_dma_pkg::ST_DATA && fifo_out_valid;
    assign o_host_tx_data  = fifo_out_data;
    assign o_sram_req      = st.rd_req || (st.to_sram && st.busy && fifo_out_valid);
    assign o_sram_we       = st.to_sram;
    assign o_sram_addr     = {{(30-WCNT_W){1'b0}}, st.sram_cnt, 2'b00};
    assign o_sram_wdata    = fifo_out_data;
    assign o_blink_req     = st.blink_req;
    assign o_led           = st.led;

    // ****************************************
    // checks
    // ****************************************
    a_scratch_readback: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        i_reg_req.wr && hit(i_reg_req, `WIN_SECOND, `OFF_SCRATCHPAD) ##1 !i_reg_req.wr ##1
        (i_reg_req.rd && !i_reg_req.wr && hit(i_reg_req, `WIN_SECOND, `OFF_SCRATCHPAD))
        |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_req.wdata, 3))
        else $error("scratchpad read differs from last write");
    a_blink_code: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        i_reg_req.wr && hit(i_reg_req, `WIN_SECOND, `OFF_BLINK_TRIGGER)
        |=> o_blink_req == ($past(i_reg_req.wdata) == `BLINK_CODE))
        else $error("blink request does not match written code");
    a_blink_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_blink_req |=> !o_blink_req)
        else $error("blink request longer than one cycle");
    a_start_clear: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        start |=> st.busy && !st.done && st.cycles == `REG_RESET ##1 st.cycles == 32'h1)
        else $error("start did not clear flag and count");
    a_count_frozen: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        st.done && !start |=> $stable(st.cycles))
        else $error("cycle count moved after completion");
    a_status_read: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        i_reg_req.rd && hit(i_reg_req, `WIN_SECOND, `OFF_DONE_STATUS)
        |=> o_reg_rdata[`STATUS_DONE_BIT] == $past(st.done))
        else $error("status read does not show completion");
    a_pkt_align: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(o_pkt_req) |-> o_pkt_addr == st.base + {st.host_cnt, 2'b00} && st.beat == 3'h0)
        else $error("packet not on a 32-byte step from base");
    a_done_count: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(st.done) |-> st.host_cnt == st.size[`PKT_BEAT_BYTES +: WCNT_W])
        else $error("words moved differ from size register");
    a_dir_code: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(st.busy) |-> st.to_sram == (st.dir == `DIR_HOST_TO_SRAM))
        else $error("direction not taken from direction code");
endmodule : pcie_dma_control_regs

// *** dv/dma_far_side_model.sv ***
// far-side model: host packet engine, host data source and sink, embedded sram
`timescale 1ns/10ps
module dma_far_side_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_clear,
    input  wire logic        i_slow,
    input  wire logic [31:0] i_base,
    input  wire logic        i_pkt_req,
    input  wire logic [31:0] i_pkt_addr,
    input  wire logic        i_pkt_to_host,
    output logic             o_pkt_ready,
    output logic             o_rx_valid,
    output logic [31:0]      o_rx_data,
    input  wire logic        i_rx_ready,
    input  wire logic        i_tx_valid,
    input  wire logic [31:0] i_tx_data,
    output logic             o_tx_ready,
    input  wire logic        i_sram_req,
    input  wire logic        i_sram_we,
    input  wire logic [31:0] i_sram_addr,
    input  wire logic [31:0] i_sram_wdata,
    output logic             o_sram_ready,
    output logic [31:0]      o_sram_rdata,
    output int               o_pkts,
    output int               o_words,
    output int               o_bad
);
    int          seed = 32'hD425;
    int          credits;
    int          rx_idx;
    logic        go;
    logic [31:0] rnd;
    logic [31:0] noise;
    logic [31:0] exp_a;

    // host memory and sram contents as the far side holds them
    function automatic logic [31:0] host_pat(input logic [31:0] a);
        return a ^ 32'h5A3C0F96;
    endfunction : host_pat
    function automatic logic [31:0] sram_pat(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction : sram_pat

    // read data only in the accepting cycle, a changing pattern otherwise
    assign o_sram_rdata = (i_sram_req && !i_sram_we && o_sram_ready) ?
                          sram_pat(i_sram_addr) : noise;

    // packet acceptor, word source and sink, sram port; stalls at random when slow
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {o_pkt_ready, o_rx_valid, o_tx_ready, o_sram_ready} <= 4'h0;
            o_rx_data <= 32'h0;
            noise <= 32'h0;
            o_pkts <= 0;
            o_words <= 0;
            o_bad <= 0;
            credits = 0;
            rx_idx = 0;
        end else begin
            rnd = $random(seed);
            noise <= ~noise ^ rnd;
            exp_a = 32'(o_words) * 32'h4;
            if (i_pkt_req && o_pkt_ready) begin
                if (i_pkt_addr !== i_base + 32'(o_pkts) * 32'h20) o_bad <= o_bad + 1;
                o_pkts <= o_pkts + 1;
                credits += i_pkt_to_host ? 0 : 8;
            end
            if (o_rx_valid && i_rx_ready) begin
                credits--;
                rx_idx++;
            end
            // a word is held until taken; the line shows garbage while idle
            if (!o_rx_valid || i_rx_ready) begin
                go = credits > 0 && (!i_slow || rnd[0]);
                o_rx_valid <= go;
                o_rx_data <= go ? host_pat(i_base + 32'(rx_idx) * 32'h4) : ~o_rx_data;
            end
            if (i_sram_req && i_sram_we && o_sram_ready) begin
                if (i_sram_addr !== exp_a || i_sram_wdata !== host_pat(i_base + exp_a)) begin
                    o_bad <= o_bad + 1;
                end
                o_words <= o_words + 1;
            end
            if (i_tx_valid && o_tx_ready) begin
                if (i_tx_data !== sram_pat(exp_a)) o_bad <= o_bad + 1;
                o_words <= o_words + 1;
            end
            o_pkt_ready <= !i_slow || rnd[1];
            o_tx_ready <= !i_slow || rnd[2];
            o_sram_ready <= !i_slow || rnd[3];
            if (i_clear) begin
                o_pkts <= 0;
                o_words <= 0;
                credits = 0;
                rx_idx = 0;
            end
        end
    end
endmodule : dma_far_side_model

// *** dv/pcie_dma_control_regs_tb_top.sv ***
// self-checking bench for the dma control registers beside a far-side model
`timescale 1ns/10ps
`include "pcie_dma_defines.svh"
module pcie_dma_control_regs_tb_top;
    logic                   i_sys_clk;
    logic                   i_arst_n;
    pcie_dma_pkg::reg_req_t i_reg_req;
    logic [31:0]            o_reg_rdata, o_pkt_addr, i_host_rx_data, o_host_tx_data;
    logic [31:0]            o_sram_addr, o_sram_wdata, i_sram_rdata, base;
    logic                   o_reg_rvalid, o_pkt_req, o_pkt_to_host, i_pkt_ready, o_blink_req;
    logic                   i_host_rx_valid, o_host_rx_ready, o_host_tx_valid, i_host_tx_ready;
    logic                   o_sram_req, o_sram_we, i_sram_ready, slow, clear;
    logic [7:0]             o_led;
    logic [3:0]             i_dip_switch;
    int                     pkts, words, bad;
    int                     cyc = 0;
    int                     mismatches = 0;
    int                     tests_run = 0;
    int                     seed = 32'hD425;
    logic [31:0]            dirs [4] = '{`DIR_HOST_TO_SRAM, `DIR_SRAM_TO_HOST,
                                         `DIR_HOST_TO_SRAM, `DIR_SRAM_TO_HOST};
    logic [31:0]            sizes [4] = '{`SIZE_8K, `SIZE_16K, `SIZE_32K, `SIZE_8K};
    logic                   slows [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    pcie_dma_control_regs uut (
        .i_sys_clk, .i_arst_n, .i_reg_req, .o_reg_rdata, .o_reg_rvalid, .o_pkt_req, .o_pkt_addr,
        .o_pkt_to_host, .i_pkt_ready, .i_host_rx_valid, .i_host_rx_data, .o_host_rx_ready,
        .o_host_tx_valid, .o_host_tx_data, .i_host_tx_ready, .o_sram_req, .o_sram_we,
        .o_sram_addr, .o_sram_wdata, .i_sram_ready, .i_sram_rdata, .o_blink_req, .o_led,
        .i_dip_switch
    );
    dma_far_side_model far (
        .i_sys_clk, .i_arst_n, .i_clear(clear), .i_slow(slow), .i_base(base),
        .i_pkt_req(o_pkt_req), .i_pkt_addr(o_pkt_addr), .i_pkt_to_host(o_pkt_to_host),
        .o_pkt_ready(i_pkt_ready), .o_rx_valid(i_host_rx_valid), .o_rx_data(i_host_rx_data),
        .i_rx_ready(o_host_rx_ready), .i_tx_valid(o_host_tx_valid), .i_tx_data(o_host_tx_data),
        .o_tx_ready(i_host_tx_ready), .i_sram_req(o_sram_req), .i_sram_we(o_sram_we),
        .i_sram_addr(o_sram_addr), .i_sram_wdata(o_sram_wdata), .o_sram_ready(i_sram_ready),
        .o_sram_rdata(i_sram_rdata), .o_pkts(pkts), .o_words(words), .o_bad(bad)
    );

    // 50 MHz clock and a free cycle counter
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) cyc <= cyc + 1;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one write, taken at the second edge
    task automatic wr(input logic win, input logic [19:0] addr, input logic [31:0] data);
        @(posedge i_sys_clk);
        i_reg_req <= '{wr: 1'b1, rd: 1'b0, win: win, addr: addr, wdata: data};
        @(posedge i_sys_clk);
        i_reg_req <= '0;
    endtask : wr

    // one read, answer looked at in the cycle after it was taken
    task automatic rd(input logic win, input logic [19:0] addr, output logic [31:0] data);
        @(posedge i_sys_clk);
        i_reg_req <= '{wr: 1'b0, rd: 1'b1, win: win, addr: addr, wdata: 32'h0};
        @(posedge i_sys_clk);
        i_reg_req <= '0;
        #1;
        chk("rvalid", 32'h1, 32'(o_reg_rvalid));
        data = o_reg_rdata;
    endtask : rd

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // watchdog against a hang
    initial begin
        repeat (80000) @(posedge i_sys_clk);
        mismatches++;
        $display("[ERR] watchdog expected finish seen timeout");
        test_done();
    end

    // main sequence
    initial begin
        logic [31:0] v;
        logic [31:0] c;
        int          t0;
        int          n;
        i_sys_clk = 1'b0;
        i_arst_n = 1'b0;
        i_reg_req = '0;
        i_dip_switch = 4'h0;
        {slow, clear} = 2'h0;
        base = 32'h0;
        repeat (2) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        #1;
        chk("pkt_req", 32'h0, 32'(o_pkt_req));
        chk("led", 32'h0, 32'(o_led));
        rd(1'b1, `OFF_SCRATCHPAD, c);
        chk("scratch reset", `REG_RESET, c);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : $random(seed);
            wr(1'b1, `OFF_SCRATCHPAD, v);
            rd(1'b1, `OFF_SCRATCHPAD, c);
            chk("scratchpad", v, c);
        end
        $display("test scratchpad done");
        rd(1'b0, `OFF_SCRATCHPAD, c);
        chk("first window 0", 32'h0, c);
        rd(1'b1, `OFF_LED_CONTROL, c);
        chk("second window led", 32'h0, c);
        v = $random(seed);
        wr(1'b0, `OFF_LED_CONTROL, v);
        #1;
        chk("led out", {24'h0, v[7:0]}, {24'h0, o_led});
        rd(1'b0, `OFF_LED_CONTROL, c);
        chk("led reg", {24'h0, v[7:0]}, c);
        @(posedge i_sys_clk);
        i_dip_switch <= v[11:8];
        rd(1'b0, `OFF_DIP_SWITCH, c);
        chk("dip", {20'h0, v[11:8], 8'h0}, c);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? `BLINK_CODE : `BLINK_CODE ^ (32'h1 << i);
            wr(1'b1, `OFF_BLINK_TRIGGER, v);
            #1;
            chk("blink pulse", 32'(i == 0), 32'(o_blink_req));
            @(posedge i_sys_clk);
            #1;
            chk("blink end", 32'h0, 32'(o_blink_req));
        end
        wr(1'b1, `OFF_DIRECTION, 32'h11AA3333);
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk("no start", 32'h0, 32'(o_pkt_req));
        rd(1'b1, `OFF_DIRECTION, c);
        chk("dir stored", 32'h11AA3333, c);
        $display("test decode and blink done");
        for (int t = 0; t < 4; t++) begin
            v = $random(seed) & 32'hFFFFFFE0;
            @(posedge i_sys_clk);
            base <= v;
            slow <= slows[t];
            clear <= 1'b1;
            @(posedge i_sys_clk);
            clear <= 1'b0;
            wr(1'b1, `OFF_HOST_BASE, v);
            wr(1'b1, `OFF_SIZE, sizes[t]);
            wr(1'b1, `OFF_DIRECTION, dirs[t]);
            #1;
            t0 = cyc;
            chk("pkt_req", 32'h1, 32'(o_pkt_req));
            chk("pkt_addr", v, o_pkt_addr);
            chk("to_host", 32'(dirs[t] == `DIR_SRAM_TO_HOST), 32'(o_pkt_to_host));
            wr(1'b1, `OFF_SIZE, 32'h00000100);
            rd(1'b1, `OFF_SIZE, c);
            chk("size locked", sizes[t], c);
            rd(1'b1, `OFF_CYCLE_COUNT, c);
            chk("count cleared", 32'h1, 32'(c <= cyc - t0 + 1));
            rd(1'b1, `OFF_DONE_STATUS, c);
            chk("busy", 32'h2, c);
            n = 0;
            while (c !== 32'h1 && n < 20000) begin
                rd(1'b1, `OFF_DONE_STATUS, c);
                n++;
            end
            chk("done", 32'h1, c);
            t0 = cyc - t0 + 1;
            rd(1'b1, `OFF_CYCLE_COUNT, c);
            chk("count range", 32'h1, 32'(c >= sizes[t] / 4 && c <= t0));
            repeat (5) @(posedge i_sys_clk);
            rd(1'b1, `OFF_CYCLE_COUNT, v);
            chk("count frozen", c, v);
            chk("packets", sizes[t] / 32, 32'(pkts));
            chk("words", sizes[t] / 4, 32'(words));
            chk("far side", 32'h0, 32'(bad));
            $display("test transfer %0d done", t);
        end
        test_done();
    end
endmodule : pcie_dma_control_regs_tb_top
